// File: logic/spi_eeprom_pin_frontend.sv
// pin front end of the serial memory: framing, shifting, pause, wake, strap, rx fifo
`timescale 1ns/1ps

// Overview of operation
// - The supply strap selects wide range mode when high and fixed high mode when low.
// - With the wake pin strapped low, chip select assertion is the wake-up source.
// - A falling chip select while active starts a transaction and resets framing.
// - A rising chip select ends the current transaction.
// - With chip select high the output is released and input traffic is ignored.
// - With the wake pin strapped low, chip select asserted during power down starts the wake and boot sequence.
// - The serial output changes only on falling serial clock edges.
// - Input bits are sampled on rising serial clock edges.
// - Asserting pause suspends the transaction without ending it.
// - While pause is low the output is released, clock and data ignored, resumed on high.
// - Transactions are whole bytes, msb first, the first byte being the command.

// ---------------------------------------------
// receive fifo
// ---------------------------------------------
module spi_fe_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 32
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ff;
   logic [AW-1:0] rd_ff;
   logic [AW:0] cnt_ff;
   logic push;
   logic pop;
   assign in_ready = cnt_ff != (AW+1)'(DEPTH);
   assign out_valid = cnt_ff != '0;
   assign out_data = mem[rd_ff];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ff] <= in_data;
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_ff <= '0;
         rd_ff <= '0;
         cnt_ff <= '0;
      end else begin
         if (push) begin
            wr_ff <= (wr_ff == AW'(DEPTH - 1)) ? '0 : wr_ff + 1'b1;
         end
         if (pop) begin
            rd_ff <= (rd_ff == AW'(DEPTH - 1)) ? '0 : rd_ff + 1'b1;
         end
         cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
   a_fifo_no_over: assert property (@(posedge clk) disable iff (rst)
      cnt_ff <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule

// ---------------------------------------------
// front end top
// ---------------------------------------------
module spi_eeprom_pin_frontend
#(
   parameter int DEPTH = spi_fe_pkg::FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic cs_n,
   input wire logic sck,
   input wire logic si,
   input wire logic hold_n,
   input wire logic wake_pin,
   input wire logic supply_range_select,
   output logic so_o,
   output logic so_oe,
   output logic wide_supply_mode,
   output logic active,
   input wire logic power_down_req,
   output logic boot_start,
   output logic txn_start,
   output logic txn_end,
   input wire logic [7:0] tx_data,
   input wire logic tx_en,
   output logic tx_take,
   output logic [7:0] rx_data,
   output logic rx_first,
   output logic rx_valid,
   input wire logic rx_ready,
   output logic rx_overrun
);
   import spi_fe_pkg::*;

   // ---------------------------------------------
   // pin synchronisers
   // ---------------------------------------------
   logic [1:0] cs_s_ff, sck_s_ff, si_s_ff, hold_s_ff, wake_s_ff, wrs_s_ff;
   logic cs_d_ff, sck_d_ff, wake_d_ff;
   // strap synchronisers keep no reset, so the pin levels are through them at release
   always_ff @(posedge clk) begin
      wake_s_ff <= {wake_s_ff[0], wake_pin};
      wrs_s_ff <= {wrs_s_ff[0], supply_range_select};
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cs_s_ff <= SYNC_RST;
         sck_s_ff <= '0;
         si_s_ff <= '0;
         hold_s_ff <= SYNC_RST;
         cs_d_ff <= 1'b1;
         sck_d_ff <= 1'b0;
         wake_d_ff <= 1'b0;
      end else begin
         cs_s_ff <= {cs_s_ff[0], cs_n};
         sck_s_ff <= {sck_s_ff[0], sck};
         si_s_ff <= {si_s_ff[0], si};
         hold_s_ff <= {hold_s_ff[0], hold_n};
         cs_d_ff <= cs_s_ff[1];
         sck_d_ff <= sck_s_ff[1];
         wake_d_ff <= wake_s_ff[1];
      end
   end
   logic cs_lo, cs_fall, cs_rise, sck_rise, sck_fall, held;
   assign cs_lo = !cs_s_ff[1];
   assign cs_fall = cs_d_ff && cs_lo;
   assign cs_rise = !cs_d_ff && !cs_lo;
   assign sck_rise = !sck_d_ff && sck_s_ff[1];
   assign sck_fall = sck_d_ff && !sck_s_ff[1];
   assign held = !hold_s_ff[1];
   // ---------------------------------------------
   // straps and power state
   // ---------------------------------------------
   logic strap_done_ff, wrs_ff, wake_used_ff;
   pwr_t pwr_ff;
   // straps are caught by the clock once synchronised, never by the reset itself
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         strap_done_ff <= 1'b0;
         wrs_ff <= 1'b0;
         wake_used_ff <= 1'b0;
      end else if (!strap_done_ff) begin
         strap_done_ff <= 1'b1;
         wrs_ff <= wrs_s_ff[1];
         wake_used_ff <= wake_s_ff[1];
      end
   end
   assign wide_supply_mode = wrs_ff;
   logic wake_ev;
   // a wake pin tied low disables its function; chip select wakes instead
   assign wake_ev = wake_used_ff ? (wake_s_ff[1] && !wake_d_ff) : cs_fall;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pwr_ff <= PWR_ACTIVE;
         boot_start <= 1'b0;
      end else begin
         boot_start <= 1'b0;
         case (pwr_ff)
            PWR_DOWN: begin
               if (strap_done_ff && wake_ev) begin
                  pwr_ff <= PWR_ACTIVE;
                  boot_start <= 1'b1;
               end
            end
            PWR_ACTIVE: begin
               if (power_down_req || (wake_used_ff && !wake_s_ff[1] && wake_d_ff)) begin
                  pwr_ff <= PWR_DOWN;
               end
            end
            default: pwr_ff <= PWR_ACTIVE;
         endcase
      end
   end
   assign active = pwr_ff == PWR_ACTIVE;

   // ---------------------------------------------
   // framing and shifting
   // ---------------------------------------------
   logic in_txn_ff, first_ff;
   logic [2:0] bit_ff;
   logic [7:0] rx_sh_ff, tx_sh_ff;
   logic run, push, fifo_ready;
   // the wake edge itself starts no transaction, it only boots the device
   assign run = in_txn_ff && cs_lo && !held;
   assign push = run && sck_rise && bit_ff == CNT_LAST;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         in_txn_ff <= 1'b0;
         first_ff <= 1'b0;
         bit_ff <= CNT_ZERO;
         rx_sh_ff <= '0;
         txn_start <= 1'b0;
         txn_end <= 1'b0;
      end else begin
         txn_start <= 1'b0;
         txn_end <= 1'b0;
         if (cs_fall && active) begin
            in_txn_ff <= 1'b1;
            first_ff <= 1'b1;
            bit_ff <= CNT_ZERO;
            txn_start <= 1'b1;
         end else if (cs_rise) begin
            in_txn_ff <= 1'b0;
            bit_ff <= CNT_ZERO; // partial byte dropped
            txn_end <= in_txn_ff;
         end else if (run && sck_rise) begin
            rx_sh_ff <= {rx_sh_ff[6:0], si_s_ff[1]};
            bit_ff <= bit_ff + 3'h1;
            if (bit_ff == CNT_LAST) begin
               first_ff <= 1'b0;
            end
         end
         // while paused only the chip select edges above still act
      end
   end
   // sticky until the next chip select fall; the set wins over the clear
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rx_overrun <= 1'b0;
      end else if (push && !fifo_ready) begin
         rx_overrun <= 1'b1;
      end else if (cs_fall) begin
         rx_overrun <= 1'b0;
      end
   end

   // output launches on falling edges only; the fall seen at bit count zero loads tx_data for the next byte
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tx_sh_ff <= '0;
         tx_take <= 1'b0;
      end else begin
         tx_take <= 1'b0;
         if (run && sck_fall) begin
            if (bit_ff == CNT_ZERO) begin
               tx_sh_ff <= tx_data;
               tx_take <= 1'b1;
            end else begin
               tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
            end
         end
      end
   end
   assign so_o = tx_sh_ff[7];
   assign so_oe = run && active && tx_en;

   spi_fe_fifo #(.WIDTH(BYTE_BITS + 1), .DEPTH(DEPTH)) rx_fifo (
      .clk(clk),
      .rst(rst),
      .in_data({first_ff, rx_sh_ff[6:0], si_s_ff[1]}),
      .in_valid(push),
      .in_ready(fifo_ready),
      .out_data({rx_first, rx_data}),
      .out_valid(rx_valid),
      .out_ready(rx_ready)
   );

   // ---------------------------------------------
   // checks
   // ---------------------------------------------
   a_so_hiz_desel: assert property (@(posedge clk) disable iff (rst)
      !cs_lo |-> !so_oe) else $error("output driven while deselected");
   a_so_hiz_hold: assert property (@(posedge clk) disable iff (rst)
      held |-> !so_oe) else $error("output driven while paused");
   a_so_fall_only: assert property (@(posedge clk) disable iff (rst)
      $changed(so_o) |-> $past(sck_fall)) else $error("output moved off fall");
   a_bit_freeze: assert property (@(posedge clk) disable iff (rst)
      (held && !cs_rise && !cs_fall) |=> $stable(bit_ff)) else $error("count moved");
   a_start_clear: assert property (@(posedge clk) disable iff (rst)
      (cs_fall && active) |=> bit_ff == CNT_ZERO && txn_start && first_ff)
      else $error("framing not reset");
   a_end_txn: assert property (@(posedge clk) disable iff (rst)
      (cs_rise && in_txn_ff) |=> txn_end && !in_txn_ff ##1 !txn_end)
      else $error("end not flagged once");
   a_cs_wake: assert property (@(posedge clk) disable iff (rst)
      (pwr_ff == PWR_DOWN && strap_done_ff && !wake_used_ff && cs_fall)
      |=> boot_start && active) else $error("no wake on select");
   a_rx_sample: assert property (@(posedge clk) disable iff (rst)
      (run && sck_rise && !cs_rise && !cs_fall) |=> rx_sh_ff[0] == $past(si_s_ff[1]))
      else $error("bit not sampled");
   a_strap_mode: assert property (@(posedge clk) disable iff (rst)
      (!strap_done_ff) |=> wide_supply_mode == $past(wrs_s_ff[1]))
      else $error("strap not taken");
endmodule

// File: logic/spi_fe_pkg.sv
// shared constants for the serial memory pin front end
package spi_fe_pkg;
   localparam int BYTE_BITS = 8;
   localparam int FIFO_DEPTH = 32;
   localparam logic [2:0] CNT_ZERO = 3'h0;
   localparam logic [2:0] CNT_LAST = 3'h7;
   localparam logic [1:0] SYNC_RST = 2'h3;
   localparam int WAKE_HOLD_NS = 200;
   localparam int CLK_NS = 100;
   localparam int WAKE_HOLD_CYC = (WAKE_HOLD_NS + CLK_NS - 1) / CLK_NS;
   typedef enum logic [0:0] {PWR_DOWN, PWR_ACTIVE} pwr_t;
endpackage

// File: dv/spi_master_model.sv
// partner model: spi master driving select, clock, data and pause pins
`timescale 1ns/1ps
// ---------------------------------------------
// spi master, mode 0
// ---------------------------------------------
module spi_master_model (
   input wire logic clk,
   input wire logic so,
   output logic cs_n,
   output logic sck,
   output logic si,
   output logic hold_n
);
   // bits seen on the returned line, taken as the clock is raised
   logic [7:0] got = 8'h00;
   initial begin
      cs_n = 1'b1;
      sck = 1'b0;
      si = 1'b0;
      hold_n = 1'b1;
   end
   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk);
   endtask
   // six cycles keep a waking select past 200 ns and past the boot
   task automatic select(input logic lvl);
      @(posedge clk);
      cs_n <= lvl;
      if (lvl) si <= ~si;
      wait_clk(6);
   endtask
   // 4 clk per phase; a released data line flips so no stale bit lingers
   task automatic send_bits(input logic [7:0] b, input int n);
      for (int i = 7; i > 7 - n; i--) begin
         @(posedge clk);
         si <= b[i];
         wait_clk(3);
         got = {got[6:0], so};
         sck <= 1'b1;
         wait_clk(4);
         sck <= 1'b0;
      end
   endtask
   // pause only with the clock low and between whole bytes
   task automatic pause(input logic lvl);
      @(posedge clk);
      hold_n <= lvl;
      wait_clk(4);
   endtask
endmodule

// File: dv/tb.sv
// self-checking bench for the serial memory pin front end
`timescale 1ns/1ps
// ---------------------------------------------
// bench top
// ---------------------------------------------
module tb;
   import spi_fe_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic strap = 1'b1;
   logic power_down_req = 1'b0;
   logic rx_ready = 1'b0;
   logic cs_n, sck, si, hold_n, so_o, so_oe, wide_supply_mode, active, boot_start;
   logic txn_start, txn_end, tx_take, rx_first, rx_valid, rx_overrun;
   logic [7:0] rx_data;
   logic [7:0] tx_data = 8'hc3;
   logic tx_en = 1'b1;
   logic wake = 1'b0;
   int num_errors = 0;
   int num_checks = 0;
   int cycles = 0;
   int n_start = 0;
   int n_end = 0;
   int n_boot = 0;
   int n_take = 0;
   localparam logic [7:0] SEQ [5] = '{8'ha5, 8'h3c, 8'h0f, 8'hf0, 8'h81};
   always #50 clk = ~clk;
   // the returned line is pulled up whenever the device lets go of it
   wire so_line = so_oe ? so_o : 1'b1;
   spi_master_model spi_master_model_i (.clk(clk), .so(so_line), .cs_n(cs_n), .sck(sck),
      .si(si), .hold_n(hold_n));
   // depth 4 so the overrun case fills the buffer within one frame
   spi_eeprom_pin_frontend #(.DEPTH(4)) spi_eeprom_pin_frontend_i (.clk(clk), .rst(rst),
      .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n), .wake_pin(wake),
      .supply_range_select(strap), .so_o(so_o), .so_oe(so_oe),
      .wide_supply_mode(wide_supply_mode), .active(active), .power_down_req(power_down_req),
      .boot_start(boot_start), .txn_start(txn_start), .txn_end(txn_end), .tx_data(tx_data),
      .tx_en(tx_en), .tx_take(tx_take), .rx_data(rx_data), .rx_first(rx_first),
      .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_overrun(rx_overrun));
   task automatic finish_test;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // pulses are counted here so no scenario can miss a one-cycle strobe
   always @(posedge clk) begin
      cycles++;
      if (txn_start === 1'b1) n_start++;
      if (txn_end === 1'b1) n_end++;
      if (boot_start === 1'b1) n_boot++;
      if (tx_take === 1'b1) n_take++;
      if (cycles == 20000) begin
         num_errors++;
         finish_test();
      end
   end
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic pop(input logic [7:0] exp, input logic first);
      int n;
      n = 0;
      @(negedge clk);
      while (rx_valid !== 1'b1 && n < 40) begin
         @(negedge clk);
         n++;
      end
      check("rx_data", exp, rx_data);
      check("rx_first", {7'h0, first}, {7'h0, rx_first});
      @(posedge clk);
      rx_ready <= 1'b1;
      @(posedge clk);
      rx_ready <= 1'b0;
   endtask
   task automatic reset_dut(input logic lvl, input logic wk);
      @(posedge clk);
      rst <= 1'b1;
      strap <= lvl;
      wake <= wk;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      repeat (5) @(negedge clk);
      check("wide_supply_mode", {7'h0, lvl}, {7'h0, wide_supply_mode});
      check("active", 8'h1, {7'h0, active});
   endtask
   // five bytes into a four deep buffer with the reader stalled
   task automatic t_fifo;
      int s0;
      s0 = n_start;
      spi_master_model_i.select(1'b0);
      check("txn_start", 8'(s0 + 1), 8'(n_start));
      for (int i = 0; i < 5; i++) spi_master_model_i.send_bits(SEQ[i], 8);
      check("so_line", 8'hc3, spi_master_model_i.got);
      repeat (5) @(negedge clk);
      check("so_oe", 8'h1, {7'h0, so_oe});
      check("so_o", 8'h1, {7'h0, so_o});
      check("tx_take", 8'h5, 8'(n_take));
      check("rx_overrun", 8'h1, {7'h0, rx_overrun});
      spi_master_model_i.select(1'b1);
      check("txn_end", 8'(s0 + 1), 8'(n_end));
      check("so_oe", 8'h0, {7'h0, so_oe});
      for (int i = 0; i < 4; i++) pop(SEQ[i], i == 0);
      @(negedge clk);
      check("rx_valid", 8'h0, {7'h0, rx_valid});
   endtask
   // pause between bytes with clock noise, then a trailing partial byte
   task automatic t_hold;
      @(posedge clk);
      tx_data <= 8'h5a;
      spi_master_model_i.select(1'b0);
      check("rx_overrun", 8'h0, {7'h0, rx_overrun});
      spi_master_model_i.send_bits(8'h96, 8);
      spi_master_model_i.pause(1'b0);
      check("so_oe", 8'h0, {7'h0, so_oe});
      spi_master_model_i.send_bits(8'hff, 3);
      spi_master_model_i.pause(1'b1);
      spi_master_model_i.send_bits(8'h3c, 8);
      check("so_line", 8'h5a, spi_master_model_i.got);
      spi_master_model_i.send_bits(8'he0, 3);
      spi_master_model_i.select(1'b1);
      pop(8'h96, 1'b1);
      pop(8'h3c, 1'b0);
      repeat (10) @(negedge clk);
      check("rx_valid", 8'h0, {7'h0, rx_valid});
   endtask
   // clocking with select high must leave nothing behind
   task automatic t_idle;
      spi_master_model_i.send_bits(8'h5a, 8);
      repeat (10) @(negedge clk);
      check("rx_valid", 8'h0, {7'h0, rx_valid});
      check("so_oe", 8'h0, {7'h0, so_oe});
   endtask
   task automatic t_wake;
      int b0;
      int s0;
      @(posedge clk);
      power_down_req <= 1'b1;
      @(posedge clk);
      power_down_req <= 1'b0;
      @(negedge clk);
      check("active", 8'h0, {7'h0, active});
      b0 = n_boot;
      s0 = n_start;
      spi_master_model_i.select(1'b0);
      spi_master_model_i.select(1'b1);
      check("boot_start", 8'(b0 + 1), 8'(n_boot));
      check("active", 8'h1, {7'h0, active});
      check("txn_start", 8'(s0), 8'(n_start));
      tx_en <= 1'b0;
      spi_master_model_i.select(1'b0);
      spi_master_model_i.send_bits(8'h06, 8);
      check("so_oe", 8'h0, {7'h0, so_oe});
      check("so_line", 8'hff, spi_master_model_i.got);
      @(posedge clk);
      tx_en <= 1'b1;
      @(negedge clk);
      check("so_oe", 8'h1, {7'h0, so_oe});
      spi_master_model_i.select(1'b1);
      pop(8'h06, 1'b1);
   endtask
   // wake pin in use: its fall powers down, select no longer wakes, its rise boots
   task automatic t_wake_pin;
      int b0;
      b0 = n_boot;
      @(posedge clk);
      wake <= 1'b0;
      repeat (6) @(negedge clk);
      check("active", 8'h0, {7'h0, active});
      spi_master_model_i.select(1'b0);
      spi_master_model_i.select(1'b1);
      check("boot_start", 8'(b0), 8'(n_boot));
      check("active", 8'h0, {7'h0, active});
      @(posedge clk);
      wake <= 1'b1;
      repeat (6) @(negedge clk);
      check("boot_start", 8'(b0 + 1), 8'(n_boot));
      check("active", 8'h1, {7'h0, active});
   endtask
   initial begin
      reset_dut(1'b1, 1'b0);
      t_fifo();
      t_hold();
      t_idle();
      t_wake();
      reset_dut(1'b0, 1'b1);
      t_wake_pin();
      finish_test();
   end
endmodule
